// ==== hw/tape_unload_pkg.sv ====
// constants, register map and state encoding of the tape unload sequencer
package tape_unload_pkg;
   // clock and timing
   localparam int CLK_HZ          = 25_000_000;
   localparam int DEBOUNCE_US     = 1000;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int TAIL_MS         = 2000;
   localparam int TAIL_CYCLES     = TAIL_MS * (CLK_HZ / 1000);
   localparam int DEB_W           = 16;
   localparam int TAIL_W          = 27;

   // register map (byte addresses)
   localparam int         ADDR_W      = 8;
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] EVENT_ADDR  = 8'h08;

   // control register bits (write one to act)
   localparam int CTRL_UNLOAD_BIT    = 0;
   localparam int CTRL_SET_READY_BIT = 1;
   localparam int CTRL_CLR_READY_BIT = 2;

   // event register bits (sticky, write one to clear)
   localparam int EVENT_DONE_BIT = 0;
   localparam int EVENT_BAIL_BIT = 1;

   // status register fields
   localparam int ST_STATE_LSB      = 0;
   localparam int ST_UNLOAD_OP_BIT  = 3;
   localparam int ST_UNLOAD_RW_BIT  = 4;
   localparam int ST_MANUAL_BIT     = 5;
   localparam int ST_READY_BIT      = 6;
   localparam int ST_TAPE_BIT       = 7;
   localparam int ST_COLS_BIT       = 8;
   localparam int ST_REELS_BIT      = 9;
   localparam int ST_VALVE_BIT      = 10;
   localparam int ST_PNEU_BIT       = 11;
   localparam int ST_WIN_RELAY_BIT  = 12;
   localparam int ST_CART_HOLD_BIT  = 13;
   localparam int ST_CART_MOTOR_BIT = 14;
   localparam int ST_VARIANT_BIT    = 15;
   localparam int ST_SWITCH_LSB     = 16;

   // reset values
   localparam logic RST_READY     = 1'b0;
   localparam logic RST_PNEU      = 1'b0;
   localparam logic RST_WIN_RELAY = 1'b0;
   localparam logic RST_CART_HOLD = 1'b0;

   // switch input indices
   localparam int SW_UNLOAD_BTN = 0;
   localparam int SW_LOAD_BTN   = 1;
   localparam int SW_RESET_BTN  = 2;
   localparam int SW_L_UPPER    = 3;
   localparam int SW_R_UPPER    = 4;
   localparam int SW_L_LOWER    = 5;
   localparam int SW_R_LOWER    = 6;
   localparam int SW_REELS      = 7;
   localparam int SW_TAPE       = 8;
   localparam int SW_WIN_UP     = 9;
   localparam int SW_WIN_DOWN   = 10;
   localparam int SW_BAIL       = 11;
   localparam int SW_CART_CLOSE = 12;
   localparam int SW_VARIANT    = 13;
   localparam int SW_N          = 14;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_DRAIN  = 3'b001,
      ST_TAKEUP = 3'b011,
      ST_WIND   = 3'b010,
      ST_TAIL   = 3'b110,
      ST_DONE   = 3'b100
   } unload_state_t;
endpackage

// ==== hw/tape_unload_sequencer.sv ====
// tape unload sequencer: reels, valves, window, cartridge, ahb-lite registers
// Behaviour
// - unload-rewind button sets unload-operation, unload-rewind and manual-status latches
// - unload start drives right reel counterclockwise, drawing tape from right column
// - basic: right reel keeps turning until loop rises above upper-left column switch
// - basic: transfer valve energised as soon as loop passes upper-left switch
// - columns-unloaded stops right reel and runs left reel clockwise
// - basic: reels-loaded drives both reels counterclockwise until tape on right reel
// - modified: columns-unloaded raised when both lower column switches transferred
// - modified: columns-unloaded activates valve and pneumatics, stops right, left clockwise
// - modified: reels-loaded drops pneumatics, both reels counterclockwise
// - reels-loaded taken from threading-channel switch as tape tightens
// - tape-present drops when tape end passes the optical sensors in final wind
// - left reel stops when tape-present drops; right reel keeps turning a delay, then stops
// - window raised only by load-rewind or reset button
// - window lowered once unload completes
// - raise: relay on, motor up until up limit opens, relay held while up
// - lower: relay off, motor reversed ignoring up limit until down limit opens
// - safety bail releases window relay so window drives down
// - end of tail delay sets unload-complete, clears cartridge hold, starts cartridge motor
// - cartridge motor stops when cartridge-closed switch transfers
// - reset button clears ready status and ready indicator
module tape_unload_sequencer #(
   parameter int DEBOUNCE_CYCLES = tape_unload_pkg::DEBOUNCE_CYCLES,
   parameter int TAIL_CYCLES     = tape_unload_pkg::TAIL_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // operator pushbuttons, high while pressed
   input  wire logic        unload_rewind_button,
   input  wire logic        load_rewind_button,
   input  wire logic        reset_button,
   // column, reel and tape sensing, high when transferred or sensed
   input  wire logic        left_column_upper_vacuum_switch,
   input  wire logic        right_column_upper_vacuum_switch,
   input  wire logic        left_column_lower_vacuum_switch,
   input  wire logic        right_column_lower_vacuum_switch,
   input  wire logic        reels_loaded_switch,
   input  wire logic        tape_sensed,
   // window and cartridge switches, limits high while closed
   input  wire logic        window_up_limit,
   input  wire logic        window_down_limit,
   input  wire logic        safety_bail_switch,
   input  wire logic        cartridge_closed_switch,
   // static variant select, high for modified sequence
   input  wire logic        variant_modified,
   // reel, pneumatic, window and cartridge drives
   output logic             right_reel_ccw,
   output logic             left_reel_cw,
   output logic             left_reel_ccw,
   output logic             transfer_valve,
   output logic             pneumatics_motor,
   output logic             window_relay,
   output logic             window_motor_up,
   output logic             window_motor_down,
   output logic             cartridge_motor,
   // status latches and indicators
   output logic             unload_operation,
   output logic             unload_rewind,
   output logic             manual_status,
   output logic             ready_indicator,
   output logic             tape_present,
   output logic             columns_unloaded,
   output logic             reels_loaded,
   output logic             unload_complete,
   output logic             cartridge_hold
);

   localparam int N = tape_unload_pkg::SW_N;

   logic [N-1:0]                     sw_raw;
   logic [N-1:0]                     sw_deb;
   logic [N-1:0]                     sw_deb_d_r;
   logic                             unload_press;
   logic                             load_press;
   logic                             reset_press;
   logic                             modified;
   tape_unload_pkg::unload_state_t   state_r;
   tape_unload_pkg::unload_state_t   state_nxt;
   logic [tape_unload_pkg::TAIL_W-1:0] tail_cnt_r;
   logic                             start;
   logic                             done_evt;
   logic                             bail_evt;
   // bus
   logic                             wr_pend_r;
   logic [tape_unload_pkg::ADDR_W-1:0] wr_addr_r;
   logic                             acc;
   logic                             sw_unload_req;
   logic                             sw_set_ready;
   logic                             sw_clr_ready;
   logic [1:0]                       event_r;
   logic [1:0]                       event_clr;
   logic [31:0]                      status_word;

   assign sw_raw = {variant_modified, cartridge_closed_switch, safety_bail_switch, window_down_limit,
                    window_up_limit, tape_sensed, reels_loaded_switch, right_column_lower_vacuum_switch,
                    left_column_lower_vacuum_switch, right_column_upper_vacuum_switch,
                    left_column_upper_vacuum_switch, reset_button, load_rewind_button, unload_rewind_button};

   // two flops then a stability counter per input; a bouncing contact never reaches the sequencer
   for (genvar i = 0; i < N; i++) begin : g_sw
      logic                                meta_r;
      logic                                sync_r;
      logic                                stable_r;
      logic [tape_unload_pkg::DEB_W-1:0]   cnt_r;
      always_ff @(posedge clk) begin
         if (reset) begin
            meta_r   <= 1'b0;
            sync_r   <= 1'b0;
            stable_r <= 1'b0;
            cnt_r    <= '0;
         end else begin
            meta_r <= sw_raw[i];
            sync_r <= meta_r;
            if (sync_r == stable_r) begin
               cnt_r <= '0;
            end else if (cnt_r == tape_unload_pkg::DEB_W'(DEBOUNCE_CYCLES - 1)) begin
               stable_r <= sync_r;
               cnt_r    <= '0;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
      assign sw_deb[i] = stable_r;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sw_deb_d_r <= '0;
      end else begin
         sw_deb_d_r <= sw_deb;
      end
   end

   // buttons act on the press edge only, so holding one does not retrigger
   assign unload_press = sw_deb[tape_unload_pkg::SW_UNLOAD_BTN] & ~sw_deb_d_r[tape_unload_pkg::SW_UNLOAD_BTN];
   assign load_press   = sw_deb[tape_unload_pkg::SW_LOAD_BTN] & ~sw_deb_d_r[tape_unload_pkg::SW_LOAD_BTN];
   assign reset_press  = sw_deb[tape_unload_pkg::SW_RESET_BTN] & ~sw_deb_d_r[tape_unload_pkg::SW_RESET_BTN];
   assign modified     = sw_deb[tape_unload_pkg::SW_VARIANT];
   assign start        = (unload_press | sw_unload_req) && state_r == tape_unload_pkg::ST_IDLE;
   assign done_evt     = state_r == tape_unload_pkg::ST_DONE;
   assign bail_evt     = sw_deb[tape_unload_pkg::SW_BAIL] & ~sw_deb_d_r[tape_unload_pkg::SW_BAIL];

   // sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tape_unload_pkg::ST_IDLE: begin
            if (start) begin
               state_nxt = tape_unload_pkg::ST_DRAIN;
            end
         end
         tape_unload_pkg::ST_DRAIN: begin
            if (modified) begin
               if (sw_deb[tape_unload_pkg::SW_L_LOWER] && sw_deb[tape_unload_pkg::SW_R_LOWER]) begin
                  state_nxt = tape_unload_pkg::ST_TAKEUP;
               end
            end else if (sw_deb[tape_unload_pkg::SW_L_UPPER]) begin
               state_nxt = tape_unload_pkg::ST_TAKEUP;
            end
         end
         tape_unload_pkg::ST_TAKEUP: begin
            if (sw_deb[tape_unload_pkg::SW_REELS]) begin
               state_nxt = tape_unload_pkg::ST_WIND;
            end
         end
         tape_unload_pkg::ST_WIND: begin
            if (!sw_deb[tape_unload_pkg::SW_TAPE]) begin
               state_nxt = tape_unload_pkg::ST_TAIL;
            end
         end
         tape_unload_pkg::ST_TAIL: begin
            if (tail_cnt_r == tape_unload_pkg::TAIL_W'(TAIL_CYCLES - 1)) begin
               state_nxt = tape_unload_pkg::ST_DONE;
            end
         end
         tape_unload_pkg::ST_DONE: state_nxt = tape_unload_pkg::ST_IDLE;
         default:                  state_nxt = tape_unload_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= tape_unload_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_r != tape_unload_pkg::ST_TAIL) begin
         tail_cnt_r <= '0;
      end else begin
         tail_cnt_r <= tail_cnt_r + 1'b1;
      end
   end

   // operation latches
   always_ff @(posedge clk) begin
      if (reset) begin
         unload_operation <= 1'b0;
         unload_rewind    <= 1'b0;
         manual_status    <= 1'b0;
      end else if (start) begin
         unload_operation <= 1'b1;
         unload_rewind    <= 1'b1;
         manual_status    <= unload_press;
      end else if (done_evt) begin
         unload_operation <= 1'b0;
         unload_rewind    <= 1'b0;
         manual_status    <= 1'b0;
      end
   end

   // reel drives and column status
   always_ff @(posedge clk) begin
      if (reset) begin
         right_reel_ccw   <= 1'b0;
         left_reel_cw     <= 1'b0;
         left_reel_ccw    <= 1'b0;
         columns_unloaded <= 1'b0;
         reels_loaded     <= 1'b0;
      end else begin
         right_reel_ccw   <= state_nxt == tape_unload_pkg::ST_DRAIN || state_nxt == tape_unload_pkg::ST_WIND ||
                             state_nxt == tape_unload_pkg::ST_TAIL;
         left_reel_cw     <= state_nxt == tape_unload_pkg::ST_TAKEUP;
         left_reel_ccw    <= state_nxt == tape_unload_pkg::ST_WIND;
         columns_unloaded <= state_nxt == tape_unload_pkg::ST_TAKEUP;
         reels_loaded     <= sw_deb[tape_unload_pkg::SW_REELS];
      end
   end

   // transfer valve: basic picks it on the loop, modified on columns unloaded
   always_ff @(posedge clk) begin
      if (reset || done_evt) begin
         transfer_valve <= 1'b0;
      end else if (state_r == tape_unload_pkg::ST_DRAIN && !modified && sw_deb[tape_unload_pkg::SW_L_UPPER]) begin
         transfer_valve <= 1'b1;
      end else if (state_r == tape_unload_pkg::ST_DRAIN && state_nxt == tape_unload_pkg::ST_TAKEUP) begin
         transfer_valve <= 1'b1;
      end
   end

   // pneumatics: modified drops them while draining and again on reels loaded
   always_ff @(posedge clk) begin
      if (reset) begin
         pneumatics_motor <= tape_unload_pkg::RST_PNEU;
      end else if (load_press) begin
         pneumatics_motor <= 1'b1;
      end else if (modified) begin
         if (start) begin
            pneumatics_motor <= 1'b0;
         end else if (state_r == tape_unload_pkg::ST_DRAIN && state_nxt == tape_unload_pkg::ST_TAKEUP) begin
            pneumatics_motor <= 1'b1;
         end else if (state_r == tape_unload_pkg::ST_TAKEUP && state_nxt == tape_unload_pkg::ST_WIND) begin
            pneumatics_motor <= 1'b0;
         end
      end else if (done_evt) begin
         pneumatics_motor <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tape_present <= 1'b0;
      end else begin
         tape_present <= sw_deb[tape_unload_pkg::SW_TAPE];
      end
   end

   // unload complete is one cycle at the end of the tail delay
   always_ff @(posedge clk) begin
      if (reset) begin
         unload_complete <= 1'b0;
      end else begin
         unload_complete <= state_r == tape_unload_pkg::ST_TAIL && state_nxt == tape_unload_pkg::ST_DONE;
      end
   end

   // ready latch
   always_ff @(posedge clk) begin
      if (reset) begin
         ready_indicator <= tape_unload_pkg::RST_READY;
      end else if (reset_press || sw_clr_ready || start) begin
         ready_indicator <= 1'b0;
      end else if (sw_set_ready) begin
         ready_indicator <= 1'b1;
      end
   end

   // window: bail beats everything, so a trapped object always lowers the window
   always_ff @(posedge clk) begin
      if (reset) begin
         window_relay <= tape_unload_pkg::RST_WIN_RELAY;
      end else if (sw_deb[tape_unload_pkg::SW_BAIL]) begin
         window_relay <= 1'b0;
      end else if (done_evt) begin
         window_relay <= 1'b0;
      end else if (load_press || reset_press) begin
         window_relay <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         window_motor_up   <= 1'b0;
         window_motor_down <= 1'b0;
      end else begin
         window_motor_up   <= window_relay && sw_deb[tape_unload_pkg::SW_WIN_UP];
         window_motor_down <= !window_relay && sw_deb[tape_unload_pkg::SW_WIN_DOWN];
      end
   end

   // cartridge
   always_ff @(posedge clk) begin
      if (reset) begin
         cartridge_hold <= tape_unload_pkg::RST_CART_HOLD;
      end else if (done_evt) begin
         cartridge_hold <= 1'b0;
      end else if (load_press) begin
         cartridge_hold <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cartridge_motor <= 1'b0;
      end else if (sw_deb[tape_unload_pkg::SW_CART_CLOSE]) begin
         cartridge_motor <= 1'b0;
      end else if (done_evt) begin
         cartridge_motor <= 1'b1;
      end
   end

   // ahb-lite slave, zero wait states; unmapped reads return zero
   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= acc && hwrite;
         if (acc) begin
            wr_addr_r <= haddr[tape_unload_pkg::ADDR_W-1:0];
         end
      end
   end

   assign sw_unload_req = wr_pend_r && wr_addr_r == tape_unload_pkg::CTRL_ADDR &&
                          hwdata[tape_unload_pkg::CTRL_UNLOAD_BIT];
   assign sw_set_ready  = wr_pend_r && wr_addr_r == tape_unload_pkg::CTRL_ADDR &&
                          hwdata[tape_unload_pkg::CTRL_SET_READY_BIT];
   assign sw_clr_ready  = wr_pend_r && wr_addr_r == tape_unload_pkg::CTRL_ADDR &&
                          hwdata[tape_unload_pkg::CTRL_CLR_READY_BIT];
   assign event_clr     = (wr_pend_r && wr_addr_r == tape_unload_pkg::EVENT_ADDR) ? hwdata[1:0] : 2'b00;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         event_r <= 2'b00;
      end else begin
         event_r[tape_unload_pkg::EVENT_DONE_BIT] <= done_evt |
            (event_r[tape_unload_pkg::EVENT_DONE_BIT] & ~event_clr[tape_unload_pkg::EVENT_DONE_BIT]);
         event_r[tape_unload_pkg::EVENT_BAIL_BIT] <= bail_evt |
            (event_r[tape_unload_pkg::EVENT_BAIL_BIT] & ~event_clr[tape_unload_pkg::EVENT_BAIL_BIT]);
      end
   end

   always_comb begin
      status_word = '0;
      status_word[tape_unload_pkg::ST_STATE_LSB +: 3]      = state_r;
      status_word[tape_unload_pkg::ST_UNLOAD_OP_BIT]       = unload_operation;
      status_word[tape_unload_pkg::ST_UNLOAD_RW_BIT]       = unload_rewind;
      status_word[tape_unload_pkg::ST_MANUAL_BIT]          = manual_status;
      status_word[tape_unload_pkg::ST_READY_BIT]           = ready_indicator;
      status_word[tape_unload_pkg::ST_TAPE_BIT]            = tape_present;
      status_word[tape_unload_pkg::ST_COLS_BIT]            = columns_unloaded;
      status_word[tape_unload_pkg::ST_REELS_BIT]           = reels_loaded;
      status_word[tape_unload_pkg::ST_VALVE_BIT]           = transfer_valve;
      status_word[tape_unload_pkg::ST_PNEU_BIT]            = pneumatics_motor;
      status_word[tape_unload_pkg::ST_WIN_RELAY_BIT]       = window_relay;
      status_word[tape_unload_pkg::ST_CART_HOLD_BIT]       = cartridge_hold;
      status_word[tape_unload_pkg::ST_CART_MOTOR_BIT]      = cartridge_motor;
      status_word[tape_unload_pkg::ST_VARIANT_BIT]         = modified;
      status_word[tape_unload_pkg::ST_SWITCH_LSB +: N]     = sw_deb;
   end

   // read data captured in the address phase, so it reflects state one cycle old
   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata <= '0;
      end else if (acc && !hwrite) begin
         case (haddr[tape_unload_pkg::ADDR_W-1:0])
            tape_unload_pkg::STATUS_ADDR: hrdata <= status_word;
            tape_unload_pkg::EVENT_ADDR:  hrdata <= {30'h0, event_r};
            default:                      hrdata <= '0;
         endcase
      end
   end

endmodule // tape_unload_sequencer

// ==== testbench/tape_plant_model.sv ====
// behavioural plant: column, reel, tape, window and cartridge sensors
module tape_plant_model (
   input  wire logic clk, reset, variant_modified, right_reel_ccw, left_reel_cw, left_reel_ccw,
   input  wire logic window_motor_up, window_motor_down, cartridge_motor,
   output logic      l_upper, l_lower, r_lower, reels, tape, win_up, win_down, cart
);
   logic [3:0] ph_r;
   int         t, pos;
   always_ff @(posedge clk) begin
      ph_r <= {right_reel_ccw, left_reel_cw, left_reel_ccw, cartridge_motor};
      t    <= (ph_r != {right_reel_ccw, left_reel_cw, left_reel_ccw, cartridge_motor}) ? 0 : t + 1;
      pos  <= reset ? 0 : pos + int'(window_motor_up && pos < 8) - int'(window_motor_down && pos > 0);
      if (reset) begin
         {l_upper, l_lower, r_lower, reels, cart, tape} <= 6'h01;
      end else if (t == 12) begin
         // sensors lag a drive change by fourteen cycles, slow enough to expose each step
         if (right_reel_ccw && !left_reel_ccw) {l_upper, l_lower, r_lower} <= {!variant_modified, {2{variant_modified}}};
         if (left_reel_cw) reels <= 1'b1;
         if (left_reel_ccw) tape <= 1'b0;
         if (cartridge_motor) cart <= 1'b1;
      end
   end
   assign win_up   = pos < 8;
   assign win_down = pos > 0;
endmodule // tape_plant_model

// ==== testbench/tape_unload_sequencer_sva.sv ====
// concurrent checks on the tape unload sequencer drive outputs
module tape_unload_sva #(parameter int DEBOUNCE_CYCLES = 4) (
   input wire logic clk, reset, variant_modified, safety_bail_switch, unload_operation, unload_complete,
   input wire logic right_reel_ccw, left_reel_cw, left_reel_ccw, transfer_valve, pneumatics_motor,
   input wire logic window_relay, window_motor_up, window_motor_down, cartridge_motor, cartridge_hold
);
   int bail_n;
   // raw pin count, so the relay is only judged once debounce has surely passed
   always_ff @(posedge clk) bail_n <= (reset || !safety_bail_switch) ? 0 : bail_n + 1;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_mod_takeup;
      variant_modified && $rose(left_reel_cw);
   endsequence
   sequence s_valve_pneu;
      ##[0:1] (transfer_valve && pneumatics_motor);
   endsequence
   a_start_right_reel: assert property ($rose(unload_operation) |-> ##[0:1] right_reel_ccw)
      else $error("right reel not started");
   a_takeup_right_off: assert property (left_reel_cw |-> !right_reel_ccw && !left_reel_ccw)
      else $error("right reel runs during takeup");
   a_mod_takeup_valve: assert property (s_mod_takeup |-> s_valve_pneu)
      else $error("valve or pneumatics missing");
   a_wind_pneu_off: assert property (variant_modified && left_reel_ccw |=> !pneumatics_motor)
      else $error("pneumatics on in wind");
   a_wind_both_ccw: assert property (!variant_modified && left_reel_ccw |-> right_reel_ccw)
      else $error("right reel off in wind");
   a_done_cartridge: assert property (unload_complete |-> ##[0:1] (cartridge_motor && !cartridge_hold))
      else $error("cartridge not closing");
   a_bail_drops_relay: assert property (bail_n > DEBOUNCE_CYCLES + 4 |-> !window_relay)
      else $error("relay held under bail");
   a_window_motor_dir: assert property ((window_motor_up |-> window_relay) and (window_motor_down |-> !window_relay))
      else $error("window motor direction wrong");
endmodule // tape_unload_sva

bind tape_unload_sequencer tape_unload_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_tape_unload_sva (.*);

// ==== testbench/tape_unload_sequencer_tb.sv ====
// self-checking testbench for the tape unload sequencer
module tape_unload_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEB = 4;
   logic        clk, reset, hsel, hwrite, hreadyout, hresp, variant_modified;
   wire logic   hready = hreadyout;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  btn;
   wire logic   unload_rewind_button = btn[0], load_rewind_button = btn[1], reset_button = btn[2];
   wire logic   safety_bail_switch = btn[3];
   logic left_column_upper_vacuum_switch, right_column_upper_vacuum_switch, left_column_lower_vacuum_switch;
   logic right_column_lower_vacuum_switch, reels_loaded_switch, tape_sensed, window_up_limit, window_down_limit;
   logic cartridge_closed_switch, right_reel_ccw, left_reel_cw, left_reel_ccw, transfer_valve, pneumatics_motor;
   logic window_relay, window_motor_up, window_motor_down, cartridge_motor, unload_operation, unload_rewind;
   logic manual_status, ready_indicator, tape_present, columns_unloaded, reels_loaded, unload_complete, cartridge_hold;
   int   mismatches, n_checks, cyc;
   tape_unload_sequencer #(.DEBOUNCE_CYCLES(DEB), .TAIL_CYCLES(20)) u_tape_unload_sequencer (.*);
   tape_plant_model u_tape_plant_model (.*, .l_upper(left_column_upper_vacuum_switch),
      .l_lower(left_column_lower_vacuum_switch), .r_lower(right_column_lower_vacuum_switch),
      .reels(reels_loaded_switch), .tape(tape_sensed), .win_up(window_up_limit),
      .win_down(window_down_limit), .cart(cartridge_closed_switch));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // master changes signals just after an edge and holds them until hready is seen high
   task automatic bus(input logic wr, input logic [31:0] a, d);
      @(posedge clk);
      {htrans, haddr, hwrite} <= {2'b10, a, wr};
      do @(posedge clk); while (hready !== 1'b1);
      {htrans, hwdata} <= {2'b00, d};
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // buttons sit in one vector so the task can drive them by index with non-blocking assignment
   task automatic press(input int i);
      @(posedge clk);
      btn[i] <= 1'b1;
      repeat (DEB + 6) @(posedge clk);
      btn[i] <= 1'b0;
   endtask
   task automatic await(ref logic s, input logic v);
      for (int i = 0; i < 200 && s !== v; i++) @(negedge clk);
   endtask
   task automatic do_reset(input logic mode);
      @(posedge clk);
      {reset, variant_modified} <= {1'b1, mode};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (DEB + 6) @(negedge clk);
   endtask
   task automatic t_basic;
      int n;
      do_reset(1'b0);
      press(0);
      chk({unload_operation, unload_rewind, manual_status, right_reel_ccw}, 4'hf);
      await(columns_unloaded, 1'b1);
      chk({transfer_valve, right_reel_ccw, left_reel_cw}, 3'b101);
      await(left_reel_ccw, 1'b1);
      chk({right_reel_ccw, left_reel_cw, reels_loaded}, 3'b101);
      await(tape_present, 1'b0);
      for (n = 0; n < 200 && right_reel_ccw === 1'b1; n++) @(negedge clk);
      chk(n >= 19 && n <= 22, 1'b1);
      @(negedge clk);
      chk({left_reel_ccw, cartridge_hold, cartridge_motor}, 3'b001);
      await(cartridge_motor, 1'b0);
      chk(cartridge_closed_switch, 1'b1);
      $display("basic unload test ended");
   endtask
   task automatic t_modified;
      do_reset(1'b1);
      bus(1'b1, tape_unload_pkg::CTRL_ADDR, 32'h1 << tape_unload_pkg::CTRL_UNLOAD_BIT);
      await(right_reel_ccw, 1'b1);
      chk({unload_operation, manual_status}, 2'b10);
      await(columns_unloaded, 1'b1);
      chk({transfer_valve, pneumatics_motor, right_reel_ccw, left_reel_cw}, 4'hd);
      await(left_reel_ccw, 1'b1);
      chk({pneumatics_motor, right_reel_ccw}, 2'b01);
      bus(1'b0, tape_unload_pkg::STATUS_ADDR, '0);
      chk({q[15], q[2:0]}, {1'b1, tape_unload_pkg::ST_WIND});
      bus(1'b0, 32'h0000_000c, '0);
      chk(q, '0);
      $display("modified unload test ended");
   endtask
   task automatic t_window;
      do_reset(1'b0);
      bus(1'b1, tape_unload_pkg::CTRL_ADDR, 32'h1 << tape_unload_pkg::CTRL_SET_READY_BIT);
      await(ready_indicator, 1'b1);
      chk(window_relay, 1'b0);
      press(1);
      await(window_motor_up, 1'b1);
      chk(window_relay, 1'b1);
      await(window_motor_up, 1'b0);
      chk({window_relay, window_up_limit}, 2'b10);
      press(3);
      await(window_motor_down, 1'b1);
      chk(window_relay, 1'b0);
      await(window_motor_down, 1'b0);
      chk(window_down_limit, 1'b0);
      press(2);
      await(window_relay, 1'b1);
      chk({window_relay, ready_indicator}, 2'b10);
      $display("window test ended");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {reset, hsel, hwrite, btn} = 7'h60;
      {right_column_upper_vacuum_switch, variant_modified} = 2'h0;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
      t_basic();
      t_modified();
      t_window();
      stop_test();
   end
endmodule // tape_unload_sequencer_tb
